/* core/ltc_ctrl.sv */
// Single-wire bus transceiver control: mode, speed, wake and fault supervision.
// Assumes host pins synchronous to clk; bus level arrives from an analogue comparator.
module ltc_ctrl #(
  parameter int WAKE_CYCLES = ltc_pkg::WAKE_CYC,
  parameter int DOM_TO_CYCLES = ltc_pkg::DOM_TO_CYC
) (
  input wire logic clk, // Core clock, 200 MHz
  input wire logic rst_n, // Async reset, active low
  input wire logic second_bus_tx_input, // Host transmit pin
  output logic second_bus_rx_output, // Host receive pin
  input wire logic bus_level_in, // Bus comparator, 1 recessive
  output logic bus_drive_low, // Pull-down transistor on
  output logic pullup_high_value, // High-value sleep pull-up connected
  output logic pullup_normal, // Normal pull-up connected
  output logic [1:0] slew_profile, // Selected speed profile
  input wire ltc_pkg::ltc_fault_t fault_in, // Analogue fault indications
  input wire ltc_pkg::ltc_dev_mode_t dev_mode, // Device mode
  output logic wake_event, // Pulse to device mode logic
  output logic supply_restart, // Pulse in supply-off low power
  output logic irq, // Level interrupt
  input wire logic [31:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [31:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready // Read data ready
);
  typedef enum logic [1:0] {
    LTC_SLEEP = 2'b01,
    LTC_TXRX = 2'b10
  } ltc_state_t;

  logic rst_meta_reg, rst_sync_reg;
  ltc_state_t state_reg;
  ltc_state_t state_next;
  logic [1:0] rate_reg;
  logic wake_en_reg;
  logic [4:0] irq_reg;
  logic [4:0] irq_next;
  logic [4:0] mask_reg;
  logic bus_prev_reg;
  logic armed_reg;
  logic low_run_reg;
  logic wake_reg;
  logic restart_reg;
  logic rx_reg;
  logic drv_reg;
  logic aw_hold_reg, w_hold_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  // Reset release through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // Dominant timeout and wake duration timers
  logic dom_to;
  logic wake_long;
  logic tx_low;
  logic bus_dom;
  assign tx_low = !second_bus_tx_input;
  assign bus_dom = !bus_level_in;
  ltc_timer #(.LIMIT(DOM_TO_CYCLES)) u_dom_timer (
    .clk(clk),
    .rst_n(rst_sync_reg),
    .run(tx_low),
    .expired(dom_to)
  );
  // Wake timer counts only a dominant run that opened with a falling edge
  ltc_timer #(.LIMIT(WAKE_CYCLES)) u_wake_timer (
    .clk(clk),
    .rst_n(rst_sync_reg),
    .run(low_run_reg),
    .expired(wake_long)
  );

  // AXI write channel decode; either channel may arrive first
  // A pending response blocks new requests: one write open at a time
  logic aw_ok, w_ok, wr_go;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready = !w_hold_reg && !bvalid_reg;
  assign aw_ok = aw_hold_reg || (s_axi_awvalid && s_axi_awready);
  assign w_ok = w_hold_reg || (s_axi_wvalid && s_axi_wready);
  assign wr_go = aw_ok && w_ok && !bvalid_reg;
  assign wr_addr = aw_hold_reg ? aw_addr_reg : s_axi_awaddr[7:0];
  assign wr_data = w_hold_reg ? w_data_reg : s_axi_wdata;
  assign wr_strb = w_hold_reg ? w_strb_reg : s_axi_wstrb;
  logic wr_ctrl, wr_irq, wr_mask, wr_hit;
  assign wr_ctrl = wr_go && wr_addr == ltc_pkg::CTRL_OFS && wr_strb[0];
  assign wr_irq = wr_go && wr_addr == ltc_pkg::IRQ_OFS && wr_strb[0];
  assign wr_mask = wr_go && wr_addr == ltc_pkg::MASK_OFS && wr_strb[0];
  assign wr_hit = wr_addr == ltc_pkg::CTRL_OFS || wr_addr == ltc_pkg::STAT_OFS ||
                  wr_addr == ltc_pkg::IRQ_OFS || wr_addr == ltc_pkg::MASK_OFS;

  // Mode request: entering transmit/receive needs tx high
  logic req_txrx, req_sleep, cmd_ignored;
  assign req_txrx = wr_ctrl && wr_data[ltc_pkg::CTRL_TXRX_BIT];
  assign req_sleep = wr_ctrl && !wr_data[ltc_pkg::CTRL_TXRX_BIT];
  assign cmd_ignored = req_txrx && tx_low && state_reg == LTC_SLEEP;
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      LTC_SLEEP: begin
        if (req_txrx && !tx_low) begin
          state_next = LTC_TXRX;
        end
      end
      LTC_TXRX: begin
        if (req_sleep) begin
          state_next = LTC_SLEEP;
        end
      end
      default: begin
        state_next = LTC_SLEEP;
      end
    endcase
  end

  // Wake: falling edge starts the timer, long dominant arms, rising edge fires
  logic fall, rise, wake_fire;
  assign fall = bus_prev_reg && bus_dom == 1'b1;
  assign rise = !bus_prev_reg && !bus_dom;
  assign wake_fire = wake_en_reg && armed_reg && rise && state_reg == LTC_SLEEP;

  // Transmit gating: both faults, the timeout, sleep and every device mode but normal force recessive
  // The timeout gates only the driver, so the host still sees the bus
  logic tx_allowed;
  assign tx_allowed = state_reg == LTC_TXRX && dev_mode.normal_mode &&
                      !fault_in.supply_uv &&
                      !fault_in.over_temp &&
                      !dom_to;

  // Sticky events; a new event wins over the clear in the same cycle
  logic [4:0] ev;
  assign ev[ltc_pkg::EV_DOM_TO] = dom_to;
  assign ev[ltc_pkg::EV_WAKE] = wake_fire;
  assign ev[ltc_pkg::EV_UV] = fault_in.supply_uv;
  assign ev[ltc_pkg::EV_OT] = fault_in.over_temp;
  assign ev[ltc_pkg::EV_CMD_IGN] = cmd_ignored;
  assign irq_next = (wr_irq ? (irq_reg & ~wr_data[4:0]) : irq_reg) | ev;

  // Read mux
  // Status bits are live levels, not snapshots
  logic [31:0] ctrl_word, stat_word, rd_word;
  logic rd_hit;
  assign ctrl_word = {28'h0, wake_en_reg, rate_reg, state_reg == LTC_TXRX};
  assign stat_word = {24'h0, state_reg == LTC_SLEEP, bus_level_in, second_bus_tx_input,
                      fault_in.over_temp, fault_in.supply_uv, 2'h0, dom_to};
  assign rd_hit = s_axi_araddr[7:0] == ltc_pkg::CTRL_OFS || s_axi_araddr[7:0] == ltc_pkg::STAT_OFS ||
                  s_axi_araddr[7:0] == ltc_pkg::IRQ_OFS || s_axi_araddr[7:0] == ltc_pkg::MASK_OFS;
  assign rd_word = s_axi_araddr[7:0] == ltc_pkg::CTRL_OFS ? ctrl_word :
                   s_axi_araddr[7:0] == ltc_pkg::STAT_OFS ? stat_word :
                   s_axi_araddr[7:0] == ltc_pkg::IRQ_OFS ? {27'h0, irq_reg} :
                   s_axi_araddr[7:0] == ltc_pkg::MASK_OFS ? {27'h0, mask_reg} : 32'h0;
  assign s_axi_arready = !rvalid_reg;

  // Control and status registers
  always_ff @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      state_reg <= LTC_SLEEP;
      rate_reg <= ltc_pkg::CTRL_RESET[2:1];
      wake_en_reg <= ltc_pkg::CTRL_RESET[3];
      irq_reg <= 5'h00;
      mask_reg <= ltc_pkg::MASK_RESET;
    end else begin
      state_reg <= state_next;
      irq_reg <= irq_next;
      if (wr_ctrl) begin
        rate_reg <= wr_data[ltc_pkg::CTRL_RATE_LSB +: 2];
        wake_en_reg <= wr_data[ltc_pkg::CTRL_WAKE_EN_BIT];
      end
      if (wr_mask) begin
        mask_reg <= wr_data[4:0];
      end
    end
  end

  // Wake detector registers
  always_ff @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      bus_prev_reg <= 1'b1; // Idle bus level, so no false edge after reset
      low_run_reg <= 1'b0;
      armed_reg <= 1'b0;
      wake_reg <= 1'b0;
      restart_reg <= 1'b0;
    end else begin
      bus_prev_reg <= !bus_dom;
      // A dominant level already present at sleep entry is not a wake pattern
      low_run_reg <= (state_reg == LTC_SLEEP) && bus_dom && (fall || low_run_reg);
      // Arm only after a long dominant that began in sleep
      armed_reg <= (state_reg == LTC_SLEEP) && (wake_long || (armed_reg && bus_dom)) && !fall;
      wake_reg <= wake_fire;
      restart_reg <= wake_fire && dev_mode.low_power_supply_off_mode;
    end
  end

  // Pin outputs from flops; receiver dark in overtemperature
  always_ff @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      rx_reg <= 1'b1;
      drv_reg <= 1'b0;
    end else begin
      rx_reg <= fault_in.over_temp ? 1'b1 : bus_level_in;
      drv_reg <= tx_allowed && tx_low;
    end
  end

  // AXI handshake registers
  always_ff @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready && !wr_go) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready && !wr_go) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_word;
        rresp_reg <= rd_hit ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  assign second_bus_rx_output = rx_reg;
  assign bus_drive_low = drv_reg;
  assign pullup_high_value = state_reg == LTC_SLEEP;
  assign pullup_normal = state_reg != LTC_SLEEP;
  assign slew_profile = rate_reg;
  assign wake_event = wake_reg;
  assign supply_restart = restart_reg;
  assign irq = |(irq_reg & mask_reg);
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
endmodule : ltc_ctrl

/* core/ltc_pkg.sv */
// Package for the single-wire bus transceiver control block.
// Assumes a 200 MHz core clock and an AXI4-Lite register port.
package ltc_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] IRQ_OFS = 8'h08;
  localparam logic [7:0] MASK_OFS = 8'h0c;
  // Control field positions
  localparam int CTRL_TXRX_BIT = 0;
  localparam int CTRL_RATE_LSB = 1;
  localparam int CTRL_WAKE_EN_BIT = 3;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // Event bit positions in sticky and mask registers
  localparam int EV_DOM_TO = 0;
  localparam int EV_WAKE = 1;
  localparam int EV_UV = 2;
  localparam int EV_OT = 3;
  localparam int EV_CMD_IGN = 4;
  localparam logic [4:0] MASK_RESET = 5'h00;
  // Timing
  localparam int CLK_MHZ = 200;
  localparam int WAKE_MIN_US = 70;
  localparam int WAKE_CYC = WAKE_MIN_US * CLK_MHZ;
  localparam int DOM_TO_US = 12000;
  localparam int DOM_TO_CYC = DOM_TO_US * CLK_MHZ;
  // Speed profiles
  typedef enum logic [1:0] {
    LTC_RATE_20K = 2'h0,
    LTC_RATE_10K = 2'h1,
    LTC_RATE_FAST = 2'h2
  } ltc_rate_t;
  // Device power modes seen from the block
  typedef struct packed {
    logic normal_mode;
    logic low_power_supply_on_mode;
    logic low_power_supply_off_mode;
  } ltc_dev_mode_t;
  // Analogue supervision indications
  typedef struct packed {
    logic supply_uv;
    logic over_temp;
  } ltc_fault_t;
endpackage : ltc_pkg

/* core/ltc_timer.sv */
// Saturating low-level timer used for wake and dominant timeouts.
// Assumes synchronous inputs and the reset copy from the top.
module ltc_timer #(
  parameter int LIMIT = 16
) (
  input wire logic clk, // Core clock
  input wire logic rst_n, // Synchronised reset
  input wire logic run, // Count while high, restart when low
  output logic expired // High once run lasted LIMIT cycles
);
  localparam int W = $clog2(LIMIT + 1);
  localparam logic [W-1:0] TOP = W'(LIMIT);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  // Saturate so a stuck input never wraps
  assign cnt_next = !run ? '0 : (cnt_reg == TOP) ? cnt_reg : cnt_reg + W'(1);

  // Counter register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign expired = (cnt_reg == TOP);
endmodule : ltc_timer

/* verification/lin_transceiver_control_tb.sv */
// Self-checking bench for the transceiver control block.
// Assumes short wake and timeout counts set here.
module lin_transceiver_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, tx, rx, bus, drv, nd, hv, nv, wk, sr, irq;
  logic [1:0] slew, bresp, rresp, rsp;
  ltc_pkg::ltc_fault_t flt;
  ltc_pkg::ltc_dev_mode_t mode;
  logic [31:0] awaddr, wdata, araddr, rdata, d;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int bad_count, num_checks, wcnt, rcnt;
  ltc_ctrl #(.WAKE_CYCLES(20), .DOM_TO_CYCLES(50)) i_dut (.clk(clk), .rst_n(rst_n),
    .second_bus_tx_input(tx), .second_bus_rx_output(rx), .bus_level_in(bus), .bus_drive_low(drv),
    .pullup_high_value(hv), .pullup_normal(nv), .slew_profile(slew), .fault_in(flt), .dev_mode(mode),
    .wake_event(wk), .supply_restart(sr), .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  ltc_bus_model i_bus (.drive_low(drv), .node_dom(nd), .bus_level(bus));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Pulse counters for wake and restart
  always @(posedge clk) begin
    if (wk === 1'b1) wcnt++;
    if (sr === 1'b1) rcnt++;
  end
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask : chk
  // Write: address and data offered together, each released when taken
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    awaddr <= {24'h0, a};
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid === 1'b1));
    rsp = bresp;
    bready <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid === 1'b1));
    d = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask : rd
  task dom(input int n);
    nd <= 1'b1;
    cyc(n);
    nd <= 1'b0;
    cyc(5);
  endtask : dom
  task t_regs;
    rd(ltc_pkg::CTRL_OFS);
    chk("ctrl", ltc_pkg::CTRL_RESET, d);
    rd(ltc_pkg::STAT_OFS);
    chk("stat", 32'h0000_00e0, d);
    rd(ltc_pkg::MASK_OFS);
    chk("mask", 32'h0, d);
    rd(8'h40);
    chk("resp", 32'h2, rsp);
    chk("rdata", 32'h0, d);
    wr(8'h40, 32'h0000_0001);
    chk("bresp", 32'h2, rsp);
  endtask : t_regs
  task t_rates;
    for (int r = 0; r < 3; r++) begin
      wr(ltc_pkg::CTRL_OFS, 32'(r * 2 + 1));
      chk("bresp", 32'h0, rsp);
      cyc(2);
      chk("slew", 32'(r), slew);
    end
    rd(ltc_pkg::CTRL_OFS);
    chk("txrx", 32'h1, d[0]);
  endtask : t_rates
  task t_link;
    tx <= 1'b0;
    cyc(3);
    chk("drive", 32'h1, drv);
    chk("rx", 32'h0, rx);
    chk("pullup", 32'h1, nv);
    tx <= 1'b1;
    cyc(3);
    chk("drive", 32'h0, drv);
    chk("rx", 32'h1, rx);
  endtask : t_link
  task t_fault;
    tx <= 1'b0;
    flt <= 2'h2;
    cyc(3);
    chk("drive", 32'h0, drv);
    flt <= 2'h0;
    cyc(3);
    chk("drive", 32'h1, drv);
    flt <= 2'h1;
    cyc(3);
    chk("drive", 32'h0, drv);
    chk("rx", 32'h1, rx);
    flt <= 2'h0;
    cyc(3);
    chk("rx", 32'h0, rx);
    mode <= 3'h2;
    cyc(3);
    chk("drive", 32'h0, drv);
    mode <= 3'h4;
    tx <= 1'b1;
    cyc(2);
  endtask : t_fault
  // One low run below the limit, one beyond it, then a short one; sticky flags cleared first
  task t_domto;
    wr(ltc_pkg::IRQ_OFS, 32'h1f);
    tx <= 1'b0;
    cyc(40);
    tx <= 1'b1;
    cyc(1);
    tx <= 1'b0;
    cyc(40);
    chk("drive", 32'h1, drv);
    cyc(20);
    chk("drive", 32'h0, drv);
    tx <= 1'b1;
    cyc(2);
    tx <= 1'b0;
    cyc(3);
    chk("drive", 32'h1, drv);
    tx <= 1'b1;
    rd(ltc_pkg::IRQ_OFS);
    chk("sticky", 32'h1, d[0]);
    chk("irq", 32'h0, irq);
    wr(ltc_pkg::MASK_OFS, 32'h1);
    cyc(2);
    chk("irq", 32'h1, irq);
    wr(ltc_pkg::IRQ_OFS, 32'h1);
    cyc(2);
    chk("irq", 32'h0, irq);
  endtask : t_domto
  task t_sleep;
    wr(ltc_pkg::CTRL_OFS, 32'h0);
    tx <= 1'b0;
    cyc(3);
    chk("hipull", 32'h1, hv);
    chk("drive", 32'h0, drv);
    wr(ltc_pkg::CTRL_OFS, 32'h1);
    rd(ltc_pkg::CTRL_OFS);
    chk("txrx", 32'h0, d[0]);
    rd(ltc_pkg::IRQ_OFS);
    chk("ignored", 32'h1, d[4]);
    tx <= 1'b1;
    dom(30);
    chk("wakes", 32'h0, wcnt);
    wr(ltc_pkg::CTRL_OFS, 32'h8);
    mode <= 3'h1;
    dom(15);
    chk("wakes", 32'h0, wcnt);
    dom(30);
    chk("wakes", 32'h1, wcnt);
    chk("restart", 32'h1, rcnt);
    mode <= 3'h2;
    dom(30);
    chk("restart", 32'h1, rcnt);
    rd(ltc_pkg::IRQ_OFS);
    chk("wakeflag", 32'h1, d[1]);
    mode <= 3'h4;
    wr(ltc_pkg::CTRL_OFS, 32'h1);
    cyc(2);
    chk("pullup", 32'h1, nv);
  endtask : t_sleep
  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    print_verdict;
  end
  initial begin
    {rst_n, nd, awvalid, wvalid, bready, arvalid, rready} = '0;
    tx = 1'b1;
    flt = 2'h0;
    mode = 3'h4;
    {awaddr, wdata, araddr} = '0;
    wstrb = 4'hf;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    cyc(3);
    t_regs;
    t_rates;
    t_link;
    t_fault;
    t_domto;
    t_sleep;
    print_verdict;
  end
endmodule : lin_transceiver_control_tb

/* verification/ltc_bus_model.sv */
// Single-wire bus with its pull-up and one other node.
// Assumes the other node is commanded by the bench.
module ltc_bus_model (
  input wire logic drive_low, // Block pull-down
  input wire logic node_dom, // Other node dominant
  output logic bus_level // 1 recessive
);
  timeunit 1ns;
  timeprecision 1ps;
  // Wired-AND: the pull-up wins unless someone pulls low
  assign bus_level = !(drive_low || node_dom);
endmodule : ltc_bus_model

/* verification/ltc_ctrl_asserts.sv */
// Checker for the transceiver control block, watching its ports only.
// Assumes one clock and the active-low asynchronous reset.
module ltc_ctrl_asserts #(
  parameter int WAKE_CYCLES = 20,
  parameter int DOM_TO_CYCLES = 50
) (
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic second_bus_tx_input, // Host tx
  input wire logic second_bus_rx_output, // Host rx
  input wire logic bus_level_in, // Bus level
  input wire logic bus_drive_low, // Pull-down
  input wire logic pullup_high_value, // Sleep pull-up
  input wire logic pullup_normal, // Normal pull-up
  input wire ltc_pkg::ltc_fault_t fault_in, // Faults
  input wire ltc_pkg::ltc_dev_mode_t dev_mode, // Mode
  input wire logic wake_event, // Wake pulse
  input wire logic supply_restart // Restart pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  int low_cnt_reg;
  int low_last_reg;
  int tx_cnt_reg;
  // Run lengths of a low bus and a low host tx; last run kept for the wake check
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt_reg <= 0;
      low_last_reg <= 0;
      tx_cnt_reg <= 0;
    end else begin
      low_cnt_reg <= bus_level_in ? 0 : low_cnt_reg + 1;
      if (bus_level_in && low_cnt_reg != 0) low_last_reg <= low_cnt_reg;
      tx_cnt_reg <= second_bus_tx_input ? 0 : tx_cnt_reg + 1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence asleep_s;
    pullup_high_value [*2];
  endsequence
  // Registered outputs: one cycle of latency allowed
  uv_recessive_a: assert property (fault_in.supply_uv |=> !bus_drive_low)
    else $error("drive during undervoltage");
  mode_gate_a: assert property (!dev_mode.normal_mode |=> !bus_drive_low)
    else $error("drive outside normal mode");
  hot_off_a: assert property (fault_in.over_temp |=> !bus_drive_low && second_bus_rx_output)
    else $error("active during overtemperature");
  tx_follow_a: assert property (bus_drive_low |-> !$past(second_bus_tx_input))
    else $error("drive without tx low");
  rx_follow_a: assert property (!fault_in.over_temp && !$past(fault_in.over_temp)
    |-> second_bus_rx_output == $past(bus_level_in))
    else $error("rx not following bus");
  pullup_pick_a: assert property (pullup_high_value != pullup_normal)
    else $error("pull-up selection wrong");
  sleep_quiet_a: assert property (asleep_s |-> !bus_drive_low)
    else $error("drive while asleep");
  wake_len_a: assert property (wake_event |-> low_last_reg >= WAKE_CYCLES)
    else $error("wake after short dominant");
  restart_a: assert property (supply_restart |-> wake_event && $past(dev_mode.low_power_supply_off_mode))
    else $error("restart without wake");
  wake_edge_a: assert property (wake_event |-> $past(bus_level_in) && !$past(bus_level_in, 2))
    else $error("wake without rising bus edge");
  wake_pulse_a: assert property (wake_event |=> !wake_event)
    else $error("wake pulse too long");
  dom_limit_a: assert property (bus_drive_low |-> tx_cnt_reg <= DOM_TO_CYCLES + 2)
    else $error("dominant beyond timeout");
endmodule : ltc_ctrl_asserts
bind ltc_ctrl ltc_ctrl_asserts #(.WAKE_CYCLES(WAKE_CYCLES), .DOM_TO_CYCLES(DOM_TO_CYCLES)) u_asserts (
  .clk(clk), .rst_n(rst_n), .second_bus_tx_input(second_bus_tx_input),
  .second_bus_rx_output(second_bus_rx_output), .bus_level_in(bus_level_in), .bus_drive_low(bus_drive_low),
  .pullup_high_value(pullup_high_value), .pullup_normal(pullup_normal), .fault_in(fault_in),
  .dev_mode(dev_mode), .wake_event(wake_event), .supply_restart(supply_restart));
